/* File: quad_xip_read_path.sv */
// Quad-I/O execute-in-place read engine of the serial flash
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// (R1) Address is six nibbles on io3..io0, most significant nibble first.
// (R2) Host clocks the programmed dummy count; mode byte sits inside it.
// (R3) After the dummy phase all four lines turn to driven outputs.
// (R4) Each byte takes two clocks: high nibble first, then low nibble.
// (R5) Chip select high ends the read and releases all four lines.
// (R6) After the last array byte reading continues from address zero, no gap.
// (R7) In continuous mode a frame starts with the address, no command.
// (R8) Select code 000..100 gives 2, 4, 6, 8, 10 dummy clocks.
// (R9) The two mode-byte clocks are part of the dummy count.
// (R10) Align flag only affects permitted frequency, and address handling.
// (R11) EBh honours the align flag; E7h ignores it and is always aligned.
// (R12) Host keeps its serial clock within the limit for its setting.
// (R13) Host uses the lower wrap-mode limits while burst wrap is on.
// (R14) Mode byte of a frame decides whether later frames skip the command.
// (R15) E7h forces the two lowest address bits to zero.
// (R16) Initial frame sends the command serially on io0, msb first.
// (R17) Mode byte enter pattern is a mask and match parameter pair.
// (R18) Host releases io lines before the device turns them around.
module quad_xip_read_path
    import xip_pkg::*;
#(
    parameter logic [7:0] MODE_MASK  = MODE_MASK_DEF,
    parameter logic [7:0] MODE_MATCH = MODE_MATCH_DEF
) (
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    input  wire logic        sclk_i,
    input  wire logic        cs_n_i,
    input  wire logic [3:0]  io_i,
    output logic      [3:0]  io_o,
    output logic      [3:0]  io_oe_n_o,
    input  wire logic [2:0]  dummy_cycle_select_i,
    input  wire logic        dword_align_flag_i,
    output logic             execute_in_place_mode_o,
    output logic             mem_req_o,
    output logic      [19:0] mem_addr_o,
    input  wire logic        mem_rvalid_i,
    input  wire logic [7:0]  mem_rdata_i,
    output logic             mem_rready_o
);

    // ------------------------------------------------------------------
    // Front end and buffer
    // ------------------------------------------------------------------
    xip_pin_if pins ();
    xip_buf_if bb ();

    xip_pin_sync u_sync (
        .mclk_i (mclk_i),
        .rst_i  (rst_i),
        .sclk_i (sclk_i),
        .cs_n_i (cs_n_i),
        .io_i   (io_i),
        .pins   (pins.tx)
    );

    xip_byte_buf u_buf (
        .mclk_i (mclk_i),
        .rst_i  (rst_i),
        .bb     (bb.sink)
    );

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        phase_t      st;
        logic        cs_prev;
        logic [3:0]  cnt;
        logic [7:0]  cmd;
        logic [23:0] addr;
        logic [7:0]  mode;
        logic        is_e7;
        logic        xip;
        logic        nib;
        logic [3:0]  lo;
        logic [3:0]  io;
        logic [3:0]  oe_n;
        logic [19:0] maddr;
        logic        req;
        logic        pend;
    } eng_t;

    eng_t        q;
    eng_t        d;
    logic [3:0]  need;
    logic [7:0]  cmd_n;
    logic [23:0] addr_n;
    logic [7:0]  mode_n;
    logic        pop_ready;
    logic        push_valid;
    logic        flush;

    assign need = dummy_clocks(dummy_cycle_select_i); // R8 R9

    always_comb begin
        d          = q;
        d.req      = 1'b0;
        d.cs_prev  = pins.cs_n;
        pop_ready  = 1'b0;
        flush      = 1'b0;
        push_valid = mem_rvalid_i & q.pend;
        cmd_n      = {q.cmd[6:0], pins.io[0]};
        addr_n     = {q.addr[19:0], pins.io};
        mode_n     = (q.cnt < MODE_CLOCKS) ? {q.mode[3:0], pins.io} : q.mode;

        // Address advances as each array read is issued; 20 bits wrap to zero
        if (q.req) begin
            d.maddr = q.maddr + 20'h0_0001; // R6
        end
        if (push_valid && bb.push_ready) begin
            d.pend = 1'b0;
        end
        // One read in flight at a time, only while the buffer has room for it
        if ((q.st == ST_DUMMY || q.st == ST_DATA) && !q.pend && !q.req
            && bb.level != BUF_DEPTH) begin
            d.req  = 1'b1;
            d.pend = 1'b1;
        end

        if (pins.cs_n) begin
            d.st   = ST_IDLE; // R5
            d.oe_n = IO_RELEASED; // R5
            d.pend = 1'b0;
            d.req  = 1'b0;
            flush  = 1'b1;
        end else if (q.cs_prev) begin
            d.st  = q.xip ? ST_ADDR : ST_CMD; // R7
            d.cnt = 4'h0;
            d.nib = 1'b0;
        end else begin
            case (q.st)
                ST_CMD: begin
                    if (pins.rise) begin
                        d.cmd = cmd_n;
                        d.cnt = q.cnt + 4'h1;
                        if (q.cnt == CMD_BITS - 4'h1) begin
                            d.cnt   = 4'h0;
                            d.is_e7 = (cmd_n == CMD_XIP_READ_DWA);
                            if (cmd_n == CMD_XIP_READ || cmd_n == CMD_XIP_READ_DWA) begin
                                d.st = ST_ADDR;
                            end else begin
                                d.st = ST_IGNORE;
                            end
                        end
                    end
                end
                ST_ADDR: begin
                    if (pins.rise) begin
                        d.addr = addr_n; // R1
                        d.cnt  = q.cnt + 4'h1;
                        if (q.cnt == ADDR_NIBBLES - 4'h1) begin
                            d.st    = ST_DUMMY;
                            d.cnt   = 4'h0;
                            d.mode  = 8'h00;
                            d.maddr = addr_n[19:0];
                            if (q.is_e7 || dword_align_flag_i) begin
                                d.maddr[1:0] = 2'b00; // R10 R11 R15
                            end
                        end
                    end
                end
                ST_DUMMY: begin
                    if (pins.rise) begin
                        d.mode = mode_n;
                        d.cnt  = q.cnt + 4'h1;
                        if (q.cnt == need - 4'h1) begin
                            d.st  = ST_DATA; // R8 R9
                            d.nib = 1'b0;
                            d.xip = ((mode_n & MODE_MASK) == MODE_MATCH); // R14 R17
                        end
                    end
                end
                ST_DATA: begin
                    if (pins.fall) begin
                        d.oe_n = IO_DRIVEN; // R3
                        d.nib  = ~q.nib;
                        if (!q.nib) begin
                            // An empty buffer here means the array port is too slow
                            pop_ready = 1'b1;
                            d.io      = bb.pop_valid ? bb.pop_data[7:4] : 4'h0; // R4
                            d.lo      = bb.pop_valid ? bb.pop_data[3:0] : 4'h0;
                        end else begin
                            d.io = q.lo; // R4
                        end
                    end
                end
                default: begin
                    d.st = q.st;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            q         <= '0;
            q.st      <= ST_IDLE;
            q.cs_prev <= 1'b1;
            q.oe_n    <= IO_RELEASED;
        end else begin
            q <= d;
        end
    end

    assign bb.push_valid = push_valid;
    assign bb.push_data  = mem_rdata_i;
    assign bb.pop_ready  = pop_ready;
    assign bb.flush      = flush;

    assign io_o                    = q.io;
    assign io_oe_n_o               = q.oe_n;
    assign execute_in_place_mode_o = q.xip;
    assign mem_req_o               = q.req;
    assign mem_addr_o              = q.maddr;
    assign mem_rready_o            = bb.push_ready;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    logic [3:0] ph_q;

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            ph_q <= 4'h0;
        end else if (d.st != q.st) begin
            ph_q <= 4'h0;
        end else if (pins.rise) begin
            ph_q <= ph_q + 4'h1;
        end
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    a_hiz_on_deselect: assert property ( // R5
        pins.cs_n |=> (io_oe_n_o == IO_RELEASED) && (q.st == ST_IDLE))
        else $error("io lines not released after deselect");

    a_oe_data_only: assert property ( // R3
        (io_oe_n_o != IO_RELEASED) |-> (q.st == ST_DATA) && (io_oe_n_o == IO_DRIVEN))
        else $error("io lines driven outside data phase or partly");

    a_addr_six_nibbles: assert property ( // R1
        (q.st == ST_ADDR) && (d.st == ST_DUMMY) |-> pins.rise && (ph_q == 4'h5))
        else $error("address phase not six clocks");

    a_dummy_count: assert property ( // R8
        (q.st == ST_DUMMY) && (d.st == ST_DATA)
        |-> (ph_q == need - 4'h1) && (need <= DUMMY_MAX) && !need[0])
        else $error("dummy phase length wrong");

    a_mode_in_dummy: assert property ( // R9
        (q.st == ST_DUMMY) && (d.st == ST_DATA) && (need == 4'h2)
        |=> (q.mode == {$past(q.mode[3:0]), $past(pins.io)}))
        else $error("mode byte not taken within two dummy clocks");

    a_e7_aligned: assert property ( // R15
        $rose(q.st == ST_DUMMY) && q.is_e7 |-> (mem_addr_o[1:0] == 2'b00))
        else $error("E7 start address not aligned");

    a_nibble_order: assert property ( // R4
        (q.st == ST_DATA) && pins.fall && !q.nib && bb.pop_valid && !pins.cs_n
        |=> (io_o == $past(bb.pop_data[7:4])) ##1 (q.lo == $past(bb.pop_data[3:0], 2)))
        else $error("high nibble not driven first");

    a_wrap_zero: assert property ( // R6
        mem_req_o && (mem_addr_o == ARRAY_LAST) |=> (mem_addr_o == 20'h0_0000))
        else $error("address did not wrap to zero");

    a_skip_command: assert property ( // R7
        $fell(pins.cs_n) && q.xip |=> (q.st == ST_ADDR))
        else $error("continuous frame did not start at address");

    a_mode_decode: assert property ( // R14
        (q.st == ST_DUMMY) && (d.st == ST_DATA)
        |=> (execute_in_place_mode_o == ((q.mode & MODE_MASK) == MODE_MATCH)))
        else $error("continuous mode flag disagrees with mode byte");

    // Continuous-mode flag may only move as a dummy phase completes
    a_xip_hold: assert property ( // R14
        (q.st != ST_DUMMY) |=> $stable(execute_in_place_mode_o))
        else $error("continuous mode flag changed outside dummy phase");

    a_ignore_quiet: assert property ( // R3
        (q.st == ST_IGNORE) |-> (io_oe_n_o == IO_RELEASED) && !mem_req_o)
        else $error("refused command drove lines or read the array");

    a_rready_pending: assert property ( // R6
        q.pend |-> mem_rready_o)
        else $error("array answer could be refused while outstanding");

    c_data_phase: cover property ($rose(q.st == ST_DATA));
    c_cont_frame: cover property ($fell(pins.cs_n) && q.xip);
    c_wrap: cover property (mem_req_o && (mem_addr_o == ARRAY_LAST));
    c_partial_byte: cover property ((q.st == ST_DATA) && q.nib && pins.cs_n);
    c_refused: cover property (q.st == ST_IGNORE);

endmodule

`default_nettype wire

/* File: xip_pkg.sv */
// Shared constants, types and helpers for the quad execute-in-place read path
package xip_pkg;

    // ------------------------------------------------------------------
    // Command codes and phase lengths
    // ------------------------------------------------------------------
    localparam logic [7:0]  CMD_XIP_READ      = 8'hEB;
    localparam logic [7:0]  CMD_XIP_READ_DWA  = 8'hE7;
    localparam logic [3:0]  CMD_BITS          = 4'h8;
    localparam logic [3:0]  ADDR_NIBBLES      = 4'h6;
    localparam logic [3:0]  MODE_CLOCKS       = 4'h2;
    localparam logic [2:0]  DC_LAST_CODE      = 3'h4;
    localparam logic [3:0]  DUMMY_MAX         = 4'hA;
    localparam logic [3:0]  DUMMY_MIN         = 4'h2;

    // ------------------------------------------------------------------
    // Array, pins and buffer
    // ------------------------------------------------------------------
    localparam int          ADDR_W            = 20;
    localparam logic [19:0] ARRAY_LAST        = 20'hF_FFFF;
    localparam logic [3:0]  IO_RELEASED       = 4'hF;
    localparam logic [3:0]  IO_DRIVEN         = 4'h0;
    localparam logic [1:0]  BUF_DEPTH         = 2'h2;

    // Continuous-mode byte decode defaults: enter when (byte & mask) == match
    localparam logic [7:0]  MODE_MASK_DEF     = 8'hF0;
    localparam logic [7:0]  MODE_MATCH_DEF    = 8'hA0;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_CMD    = 3'b001,
        ST_ADDR   = 3'b010,
        ST_DUMMY  = 3'b011,
        ST_DATA   = 3'b100,
        ST_IGNORE = 3'b101
    } phase_t;

    // Unused codes fall back to the longest setting, the safest one
    function automatic logic [3:0] dummy_clocks(input logic [2:0] dc);
        logic [3:0] n;
        n = {dc, 1'b0} + DUMMY_MIN;
        if (dc > DC_LAST_CODE) begin
            n = DUMMY_MAX;
        end
        return n;
    endfunction

endpackage

/* File: xip_if.sv */
// Interfaces between the pin front end, the byte buffer and the read engine
`timescale 1ns/1ps
`default_nettype none

interface xip_pin_if;
    logic       rise;
    logic       fall;
    logic       cs_n;
    logic [3:0] io;
    modport tx (output rise, output fall, output cs_n, output io);
    modport rx (input rise, input fall, input cs_n, input io);
endinterface

interface xip_buf_if;
    logic       push_valid;
    logic [7:0] push_data;
    logic       push_ready;
    logic       pop_valid;
    logic [7:0] pop_data;
    logic       pop_ready;
    logic [1:0] level;
    logic       flush;
    modport src  (output push_valid, output push_data, input push_ready,
                  input pop_valid, input pop_data, output pop_ready,
                  input level, output flush);
    modport sink (input push_valid, input push_data, output push_ready,
                  output pop_valid, output pop_data, input pop_ready,
                  output level, input flush);
endinterface

`default_nettype wire

/* File: xip_pin_sync.sv */
// Pin synchroniser and serial clock edge finder
`timescale 1ns/1ps
`default_nettype none

module xip_pin_sync
    import xip_pkg::*;
(
    input  wire logic       mclk_i,
    input  wire logic       rst_i,
    input  wire logic       sclk_i,
    input  wire logic       cs_n_i,
    input  wire logic [3:0] io_i,
    xip_pin_if.tx           pins
);

    typedef struct packed {
        logic [5:0] s1;
        logic [5:0] s2;
        logic [5:0] s3;
        logic       rise;
        logic       fall;
    } sync_t;

    sync_t q;
    sync_t d;

    // Bit 5 is the serial clock, bit 4 chip select, bits 3:0 the data lines.
    // The third stage keeps data aligned with the edge pulses.
    always_comb begin
        d      = q;
        d.s1   = {sclk_i, cs_n_i, io_i};
        d.s2   = q.s1;
        d.s3   = q.s2;
        d.rise = q.s2[5] & ~q.s3[5];
        d.fall = ~q.s2[5] & q.s3[5];
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            q <= '{s1: 6'h30, s2: 6'h30, s3: 6'h30, rise: 1'b0, fall: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign pins.rise = q.rise;
    assign pins.fall = q.fall;
    assign pins.cs_n = q.s3[4];
    assign pins.io   = q.s3[3:0];

endmodule

`default_nettype wire

/* File: xip_byte_buf.sv */
// Two-entry byte buffer between the array port and the nibble shifter
`timescale 1ns/1ps
`default_nettype none

module xip_byte_buf
    import xip_pkg::*;
(
    input  wire logic mclk_i,
    input  wire logic rst_i,
    xip_buf_if.sink   bb
);

    typedef struct packed {
        logic [1:0][7:0] mem;
        logic            wp;
        logic            rp;
        logic [1:0]      cnt;
        logic            room;
    } buf_t;

    buf_t q;
    buf_t d;
    logic push;
    logic pop;

    always_comb begin
        d    = q;
        push = bb.push_valid & q.room;
        pop  = bb.pop_ready & (q.cnt != 2'h0);
        if (push) begin
            d.mem[q.wp] = bb.push_data;
            d.wp        = ~q.wp;
        end
        if (pop) begin
            d.rp = ~q.rp;
        end
        d.cnt = q.cnt + {1'b0, push} - {1'b0, pop};
        if (bb.flush) begin
            d.wp  = 1'b0;
            d.rp  = 1'b0;
            d.cnt = 2'h0;
        end
        // Readiness is kept in a flop so the array port never sees a gate output
        d.room = (d.cnt != BUF_DEPTH);
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            q      <= '0;
            q.room <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign bb.push_ready = q.room;
    assign bb.pop_valid  = (q.cnt != 2'h0);
    assign bb.pop_data   = q.mem[q.rp];
    assign bb.level      = q.cnt;

endmodule

`default_nettype wire

/* File: xip_host_model.sv */
// Host-side model of the quad read link: serial clock, select and io lines
`timescale 1ns/1ps
`default_nettype none

module xip_host_model (
    input  wire logic       mclk_i,
    input  wire logic [3:0] io_o,
    input  wire logic [3:0] io_oe_n_o,
    output logic            sclk_o,
    output logic            cs_n_o,
    output logic      [3:0] io_line_o
);
    logic [3:0] drv_q;
    logic [3:0] en_q;
    logic [3:0] last_q;
    logic [7:0] rx_q [0:15];
    logic       drove_q;
    int         half;

    // ------------------------------------------------------------------
    // Wire resolution
    // ------------------------------------------------------------------
    // A released line has no pull: show a toggling level, never a held copy
    always_comb begin
        for (int b = 0; b < 4; b++) begin
            io_line_o[b] = !io_oe_n_o[b] ? io_o[b] : (en_q[b] ? drv_q[b] : ~last_q[b]);
        end
    end

    always @(posedge mclk_i) begin
        last_q <= io_line_o;
        if (!cs_n_o && io_oe_n_o !== 4'hF) begin
            drove_q <= 1'b1;
        end
    end

    // Mode 3: the serial clock stands high outside frames
    initial begin
        sclk_o  = 1'b1;
        cs_n_o  = 1'b1;
        drv_q   = 4'h0;
        en_q    = 4'h0;
        last_q  = 4'h0;
        drove_q = 1'b0;
        // Nine-cycle serial period keeps the host inside the slowest limits used here
        half    = 4;
    end

    // ------------------------------------------------------------------
    // Link tasks
    // ------------------------------------------------------------------
    // Drive after the fall, sample late in the high half, well after the answer
    task automatic clk(input logic [3:0] v, input logic [3:0] e, output logic [3:0] s);
        @(posedge mclk_i);
        sclk_o <= 1'b0;
        drv_q  <= v;
        en_q   <= e;
        repeat (half) @(posedge mclk_i);
        sclk_o <= 1'b1;
        repeat (half) @(posedge mclk_i);
        @(negedge mclk_i);
        s = io_line_o;
    endtask

    task automatic frame(input logic with_cmd, input logic [7:0] cmd, input logic [23:0] addr,
                         input logic [7:0] mode, input int dummy, input int nib);
        logic [3:0] s;
        @(posedge mclk_i);
        cs_n_o  <= 1'b0;
        drove_q <= 1'b0;
        repeat (4) @(posedge mclk_i);
        if (with_cmd) begin
            for (int i = 7; i >= 0; i--) begin
                clk({3'h0, cmd[i]}, 4'h1, s);
            end
        end
        for (int i = 5; i >= 0; i--) begin
            clk(addr[i*4 +: 4], 4'hF, s);
        end
        clk(mode[7:4], 4'hF, s);
        clk(mode[3:0], 4'hF, s);
        for (int i = 2; i < dummy; i++) begin
            clk(4'h0, 4'h0, s);
        end
        for (int i = 0; i < nib; i++) begin
            clk(4'h0, 4'h0, s);
            rx_q[i/2][7 - 4*(i%2) -: 4] = s;
        end
        @(posedge mclk_i);
        cs_n_o <= 1'b1;
        en_q   <= 4'h0;
        repeat (12) @(posedge mclk_i);
    endtask
endmodule

`default_nettype wire

/* File: quad_xip_read_path_tb.sv */
// Self-checking bench for the quad execute-in-place read path
`timescale 1ns/1ps
`default_nettype none

module quad_xip_read_path_tb
    import xip_pkg::*;
;
    logic        mclk_i;
    logic        rst_i;
    logic        sclk;
    logic        cs_n;
    wire  [3:0]  io_line;
    logic [3:0]  io_o;
    logic [3:0]  io_oe_n;
    logic [2:0]  dc;
    logic        align;
    logic        xip;
    logic        mem_req;
    logic [19:0] mem_addr;
    logic        mem_rvalid;
    logic [7:0]  mem_rdata;
    logic        mem_rready;
    logic [19:0] pa;
    int          cnt;
    int          lat;
    int          miscompares;
    int          comparisons;

    quad_xip_read_path i_dut (
        .mclk_i                  (mclk_i),
        .rst_i                   (rst_i),
        .sclk_i                  (sclk),
        .cs_n_i                  (cs_n),
        .io_i                    (io_line),
        .io_o                    (io_o),
        .io_oe_n_o               (io_oe_n),
        .dummy_cycle_select_i    (dc),
        .dword_align_flag_i      (align),
        .execute_in_place_mode_o (xip),
        .mem_req_o               (mem_req),
        .mem_addr_o              (mem_addr),
        .mem_rvalid_i            (mem_rvalid),
        .mem_rdata_i             (mem_rdata),
        .mem_rready_o            (mem_rready)
    );

    xip_host_model i_host (
        .mclk_i    (mclk_i),
        .io_o      (io_o),
        .io_oe_n_o (io_oe_n),
        .sclk_o    (sclk),
        .cs_n_o    (cs_n),
        .io_line_o (io_line)
    );

    always #2 mclk_i = ~mclk_i;

    // ------------------------------------------------------------------
    // Array stand-in and helpers
    // ------------------------------------------------------------------
    function automatic logic [7:0] pat(input logic [19:0] a);
        return a[7:0] ^ a[15:8] ^ {a[19:16], 4'h9};
    endfunction

    function automatic int dummy_of(input logic [2:0] d);
        return (d <= 3'h4) ? 2 * d + 2 : 10;
    endfunction

    // Data toggles while no answer is due, so a stale byte is never a match
    always @(posedge mclk_i) begin
        mem_rvalid <= 1'b0;
        mem_rdata  <= ~mem_rdata;
        if (mem_req) begin
            pa  <= mem_addr;
            cnt <= lat;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
            if (cnt == 1) begin
                mem_rvalid <= 1'b1;
                mem_rdata  <= pat(pa);
            end
        end
    end

    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t byte %h want %h", $time, got, exp);
        end
    endtask

    task automatic check_flag(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t flag %b want %b", $time, got, exp);
        end
    endtask

    task automatic cfg(input logic [2:0] d, input logic a);
        @(posedge mclk_i);
        dc    <= d;
        align <= a;
        // Let the new setting land before a frame reads the dummy count back
        @(posedge mclk_i);
    endtask

    task automatic read(input logic with_cmd, input logic [7:0] cmd, input logic [23:0] addr,
                        input logic [7:0] mode, input int n, input logic [19:0] first);
        i_host.frame(with_cmd, cmd, addr, mode, dummy_of(dc), 2 * n);
        for (int i = 0; i < n; i++) begin
            check_byte(i_host.rx_q[i], pat(first + 20'(i)));
        end
        check_flag(io_oe_n === IO_RELEASED, 1'b1);
        check_flag(mem_rready, 1'b1);
    endtask

    task automatic stop_test;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        mclk_i      = 1'b0;
        rst_i       = 1'b1;
        dc          = 3'h0;
        align       = 1'b0;
        mem_rdata   = 8'h00;
        cnt         = 0;
        lat         = 2;
        miscompares = 0;
        comparisons = 0;
        repeat (16) @(posedge mclk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge mclk_i);
        check_flag(io_oe_n === IO_RELEASED, 1'b1);
        read(1'b1, CMD_XIP_READ, 24'h01_2345, 8'hA0, 4, 20'h1_2345);
        check_flag(xip, 1'b1);
        $display("test enter done");
        lat = 9;
        for (int d = 1; d < 8; d++) begin
            cfg(3'(d), 1'b0);
            read(1'b0, 8'h00, 24'h00_0100 + 24'(d), 8'hA0, 2, 20'h0_0100 + 20'(d));
        end
        cfg(3'h0, 1'b0);
        read(1'b0, 8'h00, 24'h00_0200, 8'h00, 1, 20'h0_0200);
        check_flag(xip, 1'b0);
        $display("test continuous done");
        read(1'b1, CMD_XIP_READ_DWA, 24'h03_0007, 8'h00, 2, 20'h3_0004);
        cfg(3'h1, 1'b1);
        read(1'b1, CMD_XIP_READ_DWA, 24'h03_0102, 8'h00, 2, 20'h3_0100);
        read(1'b1, CMD_XIP_READ, 24'h04_000B, 8'h00, 2, 20'h4_0008);
        $display("test align done");
        cfg(3'h0, 1'b0);
        read(1'b1, CMD_XIP_READ, 24'h0F_FFFE, 8'h00, 4, ARRAY_LAST - 20'h1);
        $display("test wrap done");
        i_host.frame(1'b1, CMD_XIP_READ, 24'h00_0040, 8'h00, 2, 3);
        check_byte(i_host.rx_q[0], pat(20'h0_0040));
        check_flag(io_oe_n === IO_RELEASED, 1'b1);
        read(1'b1, CMD_XIP_READ, 24'h00_0050, 8'h00, 1, 20'h0_0050);
        i_host.frame(1'b1, 8'h03, 24'h00_0000, 8'h00, 2, 4);
        check_flag(i_host.drove_q, 1'b0);
        read(1'b1, CMD_XIP_READ, 24'h00_0060, 8'h00, 1, 20'h0_0060);
        $display("test abort done");
        i_host.half = 8;
        lat = 1;
        read(1'b1, CMD_XIP_READ, 24'h05_0000, 8'hA0, 8, 20'h5_0000);
        i_host.half = 4;
        read(1'b0, 8'h00, 24'h05_1000, 8'h00, 3, 20'h5_1000);
        $display("test stall done");
        stop_test();
    end

    initial begin
        repeat (40000) @(posedge mclk_i);
        miscompares++;
        $display("BAD t=%0t watchdog expired", $time);
        stop_test();
    end
endmodule

`default_nettype wire
